// [idiv_core.sv]
`default_nettype none
// Radix-16 restoring divider: four quotient bits per cycle, eight cycles total
module idiv_core (
	input  wire logic clk_sys_i,   // System clock
	input  wire logic rst_b_i,     // Async reset, active low
	idiv_core_if.core bus          // Launch and result bundle
);
	localparam int unsigned K = idiv_pkg::BITS_PER_CY;

	// One restoring step: shift in a bit, subtract if it fits
	function automatic logic [64:0] idiv_step(input logic [31:0] r, input logic [31:0] q,
		input logic [31:0] d);
		logic [32:0] t;
		t = {r, q[31]} - {1'b0, d};
		if (t[32]) begin
			idiv_step = {1'b0, r[30:0], q[31], q[30:0], 1'b0};
		end else begin
			idiv_step = {1'b0, t[31:0], q[30:0], 1'b1};
		end
	endfunction : idiv_step

	// Magnitude of a word under the chosen mode
	function automatic logic [31:0] idiv_abs(input logic [31:0] v, input logic s);
		idiv_abs = (s && v[31]) ? 32'(-v) : v;
	endfunction : idiv_abs

	logic [31:0] rem_ff;         // Partial remainder
	logic [31:0] quo_ff;         // Dividend shifting into quotient
	logic [31:0] dvs_ff;         // Divisor magnitude
	logic        neg_q_ff;       // Quotient to be negated
	logic        neg_r_ff;       // Remainder to be negated
	logic        zero_ff;        // Divisor was zero
	logic [3:0]  cnt_ff;         // Cycles left
	idiv_pkg::idiv_state_e state_ff;
	logic [63:0] nxt_pair;       // Remainder/quotient after K steps

	// K chained steps per clock
	always_comb begin
		logic [64:0] s;
		s = {1'b0, rem_ff, quo_ff};
		for (int i = 0; i < K; i++) begin
			s = idiv_step(s[63:32], s[31:0], dvs_ff);
		end
		nxt_pair = s[63:0];
	end

	// Sequencer and cycle count
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff <= idiv_pkg::IDIV_IDLE;
			cnt_ff   <= idiv_pkg::RST_CNT;
		end else begin
			unique case (state_ff)
				idiv_pkg::IDIV_IDLE: begin
					if (bus.start) begin
						state_ff <= idiv_pkg::IDIV_BUSY;
						cnt_ff   <= 4'(idiv_pkg::DIV_CYCLES - 1);
					end
				end
				idiv_pkg::IDIV_BUSY: begin
					cnt_ff <= cnt_ff - 4'h1;
					if (cnt_ff == 4'h0) begin
						state_ff <= idiv_pkg::IDIV_IDLE;
					end
				end
			endcase
		end
	end

	// Operand capture and iteration
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rem_ff   <= idiv_pkg::RST_WORD;
			quo_ff   <= idiv_pkg::RST_WORD;
			dvs_ff   <= idiv_pkg::RST_WORD;
			neg_q_ff <= 1'b0;
			neg_r_ff <= 1'b0;
			zero_ff  <= 1'b0;
		end else if (bus.start && state_ff == idiv_pkg::IDIV_IDLE) begin
			rem_ff   <= idiv_pkg::RST_WORD;
			quo_ff   <= idiv_abs(bus.dividend, bus.sgn);
			dvs_ff   <= idiv_abs(bus.divisor, bus.sgn);
			neg_q_ff <= bus.sgn && (bus.dividend[31] ^ bus.divisor[31]);
			neg_r_ff <= bus.sgn && bus.dividend[31];
			zero_ff  <= (bus.divisor == idiv_pkg::RST_WORD);
		end else if (state_ff == idiv_pkg::IDIV_BUSY) begin
			rem_ff <= nxt_pair[63:32];
			quo_ff <= nxt_pair[31:0];
		end
	end

	// Result outputs; zero divisor forces both to zero
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus.quot <= idiv_pkg::RST_WORD;
			bus.rem  <= idiv_pkg::RST_WORD;
		end else if (state_ff == idiv_pkg::IDIV_BUSY && cnt_ff == 4'h0) begin
			if (zero_ff) begin
				bus.quot <= idiv_pkg::RST_WORD;
				bus.rem  <= idiv_pkg::RST_WORD;
			end else begin
				bus.quot <= neg_q_ff ? 32'(-nxt_pair[31:0]) : nxt_pair[31:0];
				bus.rem  <= neg_r_ff ? 32'(-nxt_pair[63:32]) : nxt_pair[63:32];
			end
		end
	end

	assign bus.busy = (state_ff == idiv_pkg::IDIV_BUSY);
	assign bus.done = (state_ff == idiv_pkg::IDIV_BUSY) && (cnt_ff == 4'h0);

	AST_BUSY_LEN: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		$rose(bus.busy) |-> bus.busy [*8] ##1 !bus.busy)
		else $error("core busy not exactly eight cycles");
endmodule : idiv_core
`default_nettype wire

// [idiv_core_if.sv]
`default_nettype none
// Launch/operand/result bundle between control and the iterative core
interface idiv_core_if;
	logic        start;     // One-cycle launch pulse
	logic        sgn;       // Signed mode
	logic [31:0] dividend;  // Captured dividend
	logic [31:0] divisor;   // Captured divisor
	logic        busy;      // Core iterating
	logic        done;      // One-cycle completion pulse
	logic [31:0] quot;      // Final quotient
	logic [31:0] rem;       // Final remainder

	modport ctrl (output start, sgn, dividend, divisor, input busy, done, quot, rem);
	modport core (input start, sgn, dividend, divisor, output busy, done, quot, rem);
endinterface : idiv_core_if
`default_nettype wire

// [idiv_pkg.sv]
`default_nettype none
package idiv_pkg;
	// Operand and result width
	localparam int unsigned DATA_W      = 32;
	// Fixed latency from launch to final result, in clock cycles
	localparam int unsigned DIV_CYCLES  = 8;
	// Bits resolved per cycle so that DATA_W bits finish in DIV_CYCLES
	localparam int unsigned BITS_PER_CY = DATA_W / DIV_CYCLES;
	// Cycle counter width
	localparam int unsigned CNT_W       = 4;
	// Reset values
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;
	localparam logic [3:0]  RST_CNT     = 4'h0;

	// Divider sequencer states, one-hot
	typedef enum logic [1:0] {
		IDIV_IDLE = 2'b01, // No division running
		IDIV_BUSY = 2'b10  // Iterating
	} idiv_state_e;
endpackage : idiv_pkg
`default_nettype wire

// [idiv_top.sv]
`default_nettype none
module idiv_top (
	input  wire logic        clk_sys_i,      // System clock, 20 MHz
	input  wire logic        rst_b_i,        // Async reset, active low
	input  wire logic        sgn_mode_i,     // 1 = signed division
	input  wire logic        dividend_we_i,  // Dividend write strobe
	input  wire logic [31:0] dividend_i,     // Dividend write data
	input  wire logic        divisor_we_i,   // Divisor write strobe, launches
	input  wire logic [31:0] divisor_i,      // Divisor write data
	output logic      [31:0] dividend_o,     // Dividend register readback
	output logic      [31:0] divisor_o,      // Divisor register readback
	output logic      [31:0] quotient_o,     // Quotient register
	output logic      [31:0] remainder_o,    // Remainder register
	output logic             busy_o,         // Division in progress
	output logic             div_end_o,      // Division complete flag
	output logic             div_zero_o      // Divide-by-zero warning flag
);
	idiv_core_if cif ();  // Bundle to the iterative core

	logic        sgn_ff;     // Mode latched at launch
	logic        end_ff;     // Completion flag
	logic        zero_ff;    // Divide-by-zero flag
	logic        launch;     // Divisor write accepted this cycle

	// Writes during a running division are dropped so operands stay intact
	assign launch = divisor_we_i && !cif.busy;

	// Operand registers, write-protected while busy
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dividend_o <= idiv_pkg::RST_WORD;
			divisor_o  <= idiv_pkg::RST_WORD;
			sgn_ff     <= 1'b0;
		end else if (!cif.busy) begin
			if (dividend_we_i) begin
				dividend_o <= dividend_i;
			end
			if (divisor_we_i) begin
				divisor_o <= divisor_i;
				sgn_ff    <= sgn_mode_i;
			end
		end
	end

	// Launch uses current dividend and freshly written divisor; a same-cycle
	// dividend write is honoured too, passed from dividend_i straight to the core
	assign cif.start    = launch;
	assign cif.sgn      = sgn_mode_i;
	assign cif.dividend = dividend_we_i ? dividend_i : dividend_o;
	assign cif.divisor  = divisor_i;

	idiv_core u_core (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.bus       (cif.core)
	);

	// Flags: launch clears, core completion sets; launch and done never coincide
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			end_ff  <= 1'b0;
			zero_ff <= 1'b0;
		end else if (cif.done) begin
			end_ff  <= 1'b1;
			zero_ff <= (divisor_o == idiv_pkg::RST_WORD);
		end else if (launch) begin
			end_ff  <= 1'b0;
			zero_ff <= 1'b0;
		end
	end

	// Results are only valid once the flag is up; software must poll it
	assign quotient_o  = cif.quot;
	assign remainder_o = cif.rem;
	assign busy_o      = cif.busy;
	assign div_end_o   = end_ff;
	assign div_zero_o  = zero_ff;

	AST_LAUNCH_CLEARS: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		launch |=> !div_end_o && !div_zero_o)
		else $error("launch did not clear flags");

	AST_END_AT_EIGHT: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		launch |=> !div_end_o [*8] ##1 div_end_o)
		else $error("completion not eight cycles after launch");

	AST_OPERAND_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		busy_o |=> $stable(dividend_o) && $stable(divisor_o))
		else $error("operand changed during division");

	AST_ZERO_FLAG: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		launch && divisor_i == 32'h0000_0000 |-> ##9 div_zero_o)
		else $error("zero divisor not flagged");

	AST_ZERO_RESULT: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		$rose(div_end_o) && div_zero_o |-> quotient_o == 32'h0000_0000 && remainder_o == 32'h0000_0000)
		else $error("zero divisor gave nonzero result");

	AST_UNSIGNED_DIV: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		$rose(div_end_o) && !div_zero_o && !sgn_ff |->
		64'(quotient_o) * 64'(divisor_o) + 64'(remainder_o) == 64'(dividend_o) && remainder_o < divisor_o)
		else $error("unsigned result inconsistent");

	AST_SIGNED_DIV: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		$rose(div_end_o) && !div_zero_o && sgn_ff |->
		32'($signed(quotient_o) * $signed(divisor_o) + $signed(remainder_o)) == dividend_o &&
		(remainder_o == 32'h0000_0000 || remainder_o[31] == dividend_o[31]))
		else $error("signed result inconsistent");

	// A write in the final busy cycle must neither relaunch nor swallow completion
	AST_DROP_BUSY_WRITE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		divisor_we_i && cif.done |=> !busy_o && $rose(div_end_o))
		else $error("write in last busy cycle relaunched");

	// Flags stand until the next launch
	AST_FLAGS_STAND: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		div_end_o && !launch |=> div_end_o && $stable(div_zero_o))
		else $error("flags changed without a launch");

	// Mode is taken with the launching divisor write
	AST_MODE_LATCH: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		launch |=> busy_o && sgn_ff == $past(sgn_mode_i))
		else $error("mode not latched at launch");

	// Results only move at completion
	AST_RESULT_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!cif.done |=> $stable(quotient_o) && $stable(remainder_o))
		else $error("results changed outside completion");
endmodule : idiv_top
`default_nettype wire

// [idiv_top_tb.sv]
`default_nettype none
// Compare one design value against its expected value and keep the tallies
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin err_count++; \
	$display("Error %0t: mismatch got %h exp %h", $time, (act), (exp)); end end

module idiv_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys_i;    // 20 MHz clock
	logic        rst_b_i;      // Async reset, active low
	logic        sgn;          // Signed mode request
	logic        dvd_we;       // Dividend write strobe
	logic [31:0] dvd;          // Dividend data
	logic        dvs_we;       // Divisor write strobe
	logic [31:0] dvs;          // Divisor data
	logic [31:0] dividend_o;   // Dividend readback
	logic [31:0] divisor_o;    // Divisor readback
	logic [31:0] quotient_o;   // Quotient
	logic [31:0] remainder_o;  // Remainder
	logic        busy_o;       // Division running
	logic        div_end_o;    // Completion flag
	logic        div_zero_o;   // Zero divisor flag
	int          err_count;    // Mismatches
	int          num_checks;   // Comparisons made

	idiv_top i_dut (
		.clk_sys_i     (clk_sys_i),
		.rst_b_i       (rst_b_i),
		.sgn_mode_i    (sgn),
		.dividend_we_i (dvd_we),
		.dividend_i    (dvd),
		.divisor_we_i  (dvs_we),
		.divisor_i     (dvs),
		.dividend_o    (dividend_o),
		.divisor_o     (divisor_o),
		.quotient_o    (quotient_o),
		.remainder_o   (remainder_o),
		.busy_o        (busy_o),
		.div_end_o     (div_end_o),
		.div_zero_o    (div_zero_o)
	);

	// Free running clock, 50 ns period
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	// Verdict and end of run, shared with the watchdog
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out

	// Write both operands in one cycle; the divisor write launches
	task automatic launch(input logic s, input logic [31:0] a, input logic [31:0] b);
		sgn    = s;
		dvd    = a;
		dvs    = b;
		dvd_we = 1'b1;
		dvs_we = 1'b1;
		@(negedge clk_sys_i);
		dvd_we = 1'b0;
		dvs_we = 1'b0;
	endtask : launch

	// Count busy cycles, then judge flags, results and operand readback
	task automatic finish_div(input int exp_n, input logic [31:0] a, input logic [31:0] b,
			input logic [31:0] q, input logic [31:0] r, input logic z);
		int n;
		n = 0;
		while (div_end_o !== 1'b1 && n < 20) begin
			n++;
			@(negedge clk_sys_i);
		end
		`CHK(n, exp_n)
		`CHK(busy_o, 1'b0)
		`CHK(div_end_o, 1'b1)
		`CHK(quotient_o, q)
		`CHK(remainder_o, r)
		`CHK(div_zero_o, z)
		`CHK(dividend_o, a)
		`CHK(divisor_o, b)
	endtask : finish_div

	// One whole division; next launch lands in the cycle busy falls
	task automatic run(input logic s, input logic [31:0] a, input logic [31:0] b,
			input logic [31:0] q, input logic [31:0] r);
		launch(s, a, b);
		`CHK(busy_o, 1'b1)
		`CHK(div_end_o, 1'b0)
		`CHK(div_zero_o, 1'b0)
		finish_div(8, a, b, q, r, (b == 32'h0000_0000));
	endtask : run

	// Zero divisor in both modes, zero results and warning
	task automatic t_zero();
		run(1'b0, 32'h1234_5678, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
		run(1'b1, 32'h8765_4321, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
		$display("test zero done");
	endtask : t_zero

	// Unsigned table, expectations from the bench's own arithmetic
	task automatic t_unsigned();
		logic [31:0] av [4] = '{32'h0000_0064, 32'hFFFF_FFFF, 32'h8000_0000, 32'h0000_0003};
		logic [31:0] bv [4] = '{32'h0000_0007, 32'h0000_0001, 32'h0000_0003, 32'hFFFF_FFFF};
		for (int i = 0; i < 4; i++) begin
			run(1'b0, av[i], bv[i], av[i] / bv[i], av[i] % bv[i]);
		end
		$display("test unsigned done");
	endtask : t_unsigned

	// Signed: truncation toward zero, remainder sign follows dividend
	task automatic t_signed();
		logic signed [31:0] av [4] = '{-32'sd7, 32'sd7, -32'sd7, 32'sd100};
		logic signed [31:0] bv [4] = '{32'sd2, -32'sd2, -32'sd2, 32'sd9};
		for (int i = 0; i < 4; i++) begin
			run(1'b1, av[i], bv[i], av[i] / bv[i], av[i] % bv[i]);
		end
		// Overflow case settled by the designer
		run(1'b1, 32'h8000_0000, 32'hFFFF_FFFF, 32'h8000_0000, 32'h0000_0000);
		$display("test signed done");
	endtask : t_signed

	// Writes during a running division are dropped and cause no relaunch
	task automatic t_refused();
		launch(1'b0, 32'h0000_00C8, 32'h0000_0009);
		@(negedge clk_sys_i);
		dvd    = 32'h0000_0001;
		dvs    = 32'h0000_0000;
		dvd_we = 1'b1;
		dvs_we = 1'b1;
		// Held through the final busy cycle too, where a relaunch would hurt most
		repeat (7) @(negedge clk_sys_i);
		dvd_we = 1'b0;
		dvs_we = 1'b0;
		finish_div(0, 32'h0000_00C8, 32'h0000_0009, 32'h0000_0016, 32'h0000_0002, 1'b0);
		@(negedge clk_sys_i);
		`CHK(busy_o, 1'b0)
		`CHK(div_end_o, 1'b1)
		$display("test refused done");
	endtask : t_refused

	// Main sequence: reset for 10 cycles, then the scenarios
	initial begin
		err_count  = 0;
		num_checks = 0;
		rst_b_i    = 1'b0;
		sgn        = 1'b0;
		dvd_we     = 1'b0;
		dvs_we     = 1'b0;
		dvd        = 32'h0000_0000;
		dvs        = 32'h0000_0000;
		repeat (10) @(negedge clk_sys_i);
		`CHK(div_end_o, 1'b0)
		rst_b_i = 1'b1;
		@(negedge clk_sys_i);
		t_zero();
		t_unsigned();
		t_signed();
		t_refused();
		close_out();
	end

	// Watchdog, well beyond the roughly 120 cycles the tests need
	initial begin
		repeat (5000) @(posedge clk_sys_i);
		err_count++;
		$display("Error %0t: watchdog expired", $time);
		close_out();
	end
endmodule : idiv_top_tb
`default_nettype wire
